// File: design/sync_serial_port.sv
// Serial port pin control, GPIO fallback, framing and exceptions
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"

// Notes on behaviour
// - Each pin-select bit gives its pin to the serial engine, else GPIO.
// - Port drive enable cleared makes every pin high impedance.
// - Bit 6 and bits 8 to 15 of pin control read zero.
// - GPIO direction bit set means output, cleared means input.
// - Reset clears the direction register.
// - GPIO data reads live level on input pins, written value on output pins; written value drives output pins.
// - Reset clears the pin data register.
// - Serial engine held in reset while no pin is serial.
// - Clearing all pin selects resets status but keeps control registers.
// - Data register accesses during individual reset have no defined effect.
// - Exception priority: rx error, rx, rx last, tx error, tx last, tx.
// - Rx error exception on full buffer with overrun; status then rx read.
// - Rx exception on full buffer without error; rx read clears it.
// - Rx last-slot exception after final slot ends, slot mode only.
// - Tx error exception on empty with underrun; status then write clears.
// - Tx last-slot exception at start of final slot, slot mode only.
// - Tx exception on empty without error; tx or null write clears it.
// - One word per frame, or 2 to 32 slots in slot mode.
// - On-demand mode sends frame sync only when transmit data waits.
// - On-demand: tx frame sync is output, rx frame sync is input.
// - On-demand holds one pending word and disables underrun.
// - Overrun set when a finished word meets a full receive buffer.
// - Underrun set when a slot has no new data; last word resent.
module sync_serial_port
    import sync_serial_pkg::*;
#(
    parameter bit PORT_B = 1'b0 // Selects the second register bank
) (
    input wire logic ref_clk, // System clock, 125 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic clk_en, // Freezes all state while low
    input wire logic [15:0] addr, // Register address
    input wire logic [15:0] wr_data, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [15:0] rd_data, // Read data, cycle after strobe
    input wire logic [5:0] pin_i, // Pin levels seen at the pads
    output logic [5:0] pin_o, // Pin drive values
    output logic [5:0] pin_oe, // Pin drive enables, high drives
    output logic exc_req, // Any exception pending
    output exc_code_t exc_code // Highest pending exception
);
    localparam logic [15:0] A_PDATA = PORT_B ? `ADR_B_PDATA : `ADR_A_PDATA;
    localparam logic [15:0] A_PDIR = PORT_B ? `ADR_B_PDIR : `ADR_A_PDIR;
    localparam logic [15:0] A_PFUNC = PORT_B ? `ADR_B_PFUNC : `ADR_A_PFUNC;
    localparam logic [15:0] A_CTL1 = PORT_B ? `ADR_B_CTL1 : `ADR_A_CTL1;
    localparam logic [15:0] A_CTL2 = PORT_B ? `ADR_B_CTL2 : `ADR_A_CTL2;
    localparam logic [15:0] A_CTL3 = PORT_B ? `ADR_B_CTL3 : `ADR_A_CTL3;
    localparam logic [15:0] A_STAT = PORT_B ? `ADR_B_STAT : `ADR_A_STAT;
    localparam logic [15:0] A_RXD = PORT_B ? `ADR_B_RXD : `ADR_A_RXD;
    localparam logic [15:0] A_TXD = PORT_B ? `ADR_B_TXD : `ADR_A_TXD;
    localparam logic [15:0] A_NULL = PORT_B ? `ADR_B_NULL : `ADR_A_NULL;

    logic [5:0] psel_q;
    logic [5:0] pdir_q;
    logic [5:0] pdat_q;
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic pen_q, sclk_prev_q;
    logic [7:0] ctl1_q;
    logic [7:0] ctl2_q;
    logic [7:0] ctl3_q;
    logic [15:0] rd_data_q;
    logic [15:0] rx_buf_q;
    logic [15:0] rx_sh_q;
    logic [15:0] tx_buf_q;
    logic [15:0] tx_sh_q;
    logic [15:0] tx_last_q;
    logic rdf_q, roe_q, tde_q, tue_q, null_q, roe_arm_q, tue_arm_q;
    logic rls_q, tls_q, tx_fs_q, tx_out_q, tx_drive_q, rx_act_q;
    logic [4:0] rx_cnt_q;
    logic [4:0] rx_slot_q;
    logic [4:0] tx_slot_q;
    logic [3:0] tx_cnt_q;
    tx_state_t tx_st_q;

    // Decodes and derived controls
    logic ir, eng_rst, wr_tx, wr_null, rd_rx, rd_stat, net, ondem;
    logic sclk, rise, fall, rfs, rx_word_done, tx_start, underrun;
    logic [4:0] last_slot;
    assign ir = ~|psel_q;
    assign eng_rst = sys_rst | ir;
    assign wr_tx = wr_en & (addr == A_TXD) & ~ir;
    assign wr_null = wr_en & (addr == A_NULL) & ~ir;
    assign rd_rx = rd_en & (addr == A_RXD) & ~ir;
    assign rd_stat = rd_en & (addr == A_STAT);
    assign net = ctl3_q[`C3_SLOTS];
    assign ondem = net & (ctl1_q[4:0] == 5'h00);
    assign last_slot = net ? ctl1_q[4:0] : 5'h00;

    // Bit clock sampled by the system clock; edges from settled stages
    // Previous level follows the pad, so selecting the pin fakes no edge
    assign sclk = sync2_q[`PIN_SCLK];
    assign rise = psel_q[`PIN_SCLK] & sclk & ~sclk_prev_q;
    assign fall = psel_q[`PIN_SCLK] & ~sclk & sclk_prev_q;
    // Shared timing lets the receiver follow the internal sync
    assign rfs = (ctl3_q[`C3_SHARED] & ~ondem) ? tx_fs_q
               : sync2_q[`PIN_RFS] & psel_q[`PIN_RFS];
    assign rx_word_done = fall & rx_act_q
                        & (rx_cnt_q == 5'(`WORD_BITS - 1));
    // On-demand only starts a slot when a word is waiting
    assign tx_start = rise & ctl2_q[`C2_TX_EN]
                    & (tx_st_q == TX_IDLE || tx_cnt_q == 4'h0)
                    & (~ondem | ~tde_q);
    assign underrun = tx_start & tde_q & ~ondem;

    // Pin synchronisers: two stages before any logic
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            sclk_prev_q <= 1'b0;
        end else if (clk_en) begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            sclk_prev_q <= sclk;
        end
    end

    // Port pin registers; upper bits never stored
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            psel_q <= `PIN_RST;
            pen_q <= 1'b0;
            pdir_q <= `PIN_RST;
            pdat_q <= `PIN_RST;
        end else if (clk_en && wr_en) begin
            if (addr == A_PFUNC) begin
                psel_q <= wr_data[5:0];
                pen_q <= wr_data[`PFUNC_EN_BIT];
            end
            if (addr == A_PDIR)
                pdir_q <= wr_data[5:0];
            if (addr == A_PDATA)
                pdat_q <= wr_data[5:0];
        end
    end

    // Control registers survive individual reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctl1_q <= `CTL_RST;
            ctl2_q <= `CTL_RST;
            ctl3_q <= `CTL_RST;
        end else if (clk_en && wr_en) begin
            if (addr == A_CTL1)
                ctl1_q <= wr_data[7:0];
            if (addr == A_CTL2)
                ctl2_q <= wr_data[7:0];
            if (addr == A_CTL3)
                ctl3_q <= wr_data[7:0];
        end
    end

    // Receive shifter: MSB first, sampled on falling bit clock
    always_ff @(posedge ref_clk) begin
        if (eng_rst) begin
            rx_act_q <= 1'b0;
            rx_cnt_q <= 5'h00;
            rx_slot_q <= 5'h00;
            rx_sh_q <= 16'h0000;
        end else if (clk_en && fall && ctl2_q[`C2_RX_EN]) begin
            if (rfs && (!rx_act_q || rx_cnt_q == 5'h00)) begin
                rx_act_q <= 1'b1;
                rx_slot_q <= 5'h00;
                rx_cnt_q <= 5'h01;
                rx_sh_q <= {15'h0000, sync2_q[`PIN_RXD]};
            end else if (rx_act_q) begin
                rx_sh_q <= {rx_sh_q[14:0], sync2_q[`PIN_RXD]};
                if (rx_word_done) begin
                    rx_cnt_q <= 5'h00;
                    // Stay active until the final slot is in
                    if (rx_slot_q == last_slot)
                        rx_act_q <= 1'b0;
                    else
                        rx_slot_q <= rx_slot_q + 5'h01;
                end else begin
                    rx_cnt_q <= rx_cnt_q + 5'h01;
                end
            end
        end
    end

    // Receive buffer and its flags; hardware set beats software clear
    always_ff @(posedge ref_clk) begin
        if (eng_rst) begin
            rx_buf_q <= 16'h0000;
            rdf_q <= 1'b0;
            roe_q <= 1'b0;
            roe_arm_q <= 1'b0;
            rls_q <= 1'b0;
        end else if (clk_en) begin
            if (rd_stat && roe_q)
                roe_arm_q <= 1'b1;
            if (rd_rx)
                rdf_q <= 1'b0;
            if (rd_rx && roe_arm_q) begin
                roe_q <= 1'b0;
                roe_arm_q <= 1'b0;
            end
            if (rd_stat)
                rls_q <= 1'b0;
            if (rx_word_done) begin
                // Old word is kept on overrun; the new one is lost
                if (rdf_q && !rd_rx) begin
                    roe_q <= 1'b1;
                end else begin
                    rx_buf_q <= {rx_sh_q[14:0], sync2_q[`PIN_RXD]};
                    rdf_q <= 1'b1;
                end
                if (net && rx_slot_q == last_slot)
                    rls_q <= 1'b1;
            end
        end
    end

    // Transmit slot sequencer and shifter, updated on rising bit clock
    always_ff @(posedge ref_clk) begin
        if (eng_rst) begin
            tx_st_q <= TX_IDLE;
            tx_cnt_q <= 4'h0;
            tx_slot_q <= 5'h00;
            tx_sh_q <= 16'h0000;
            tx_last_q <= 16'h0000;
            tx_out_q <= 1'b0;
            tx_fs_q <= 1'b0;
            tx_drive_q <= 1'b0;
        end else if (clk_en && rise) begin
            tx_fs_q <= 1'b0;
            if (tx_start) begin
                tx_st_q <= TX_SHIFT;
                tx_cnt_q <= 4'h1;
                // Sync pulse lasts the first bit of the frame
                tx_fs_q <= (tx_slot_q == 5'h00) | ondem;
                if (!tde_q && null_q) begin
                    tx_drive_q <= 1'b0;
                end else if (!tde_q) begin
                    tx_drive_q <= 1'b1;
                    tx_last_q <= tx_buf_q;
                    tx_out_q <= tx_buf_q[15];
                    tx_sh_q <= {tx_buf_q[14:0], 1'b0};
                end else begin
                    tx_drive_q <= 1'b1;
                    tx_out_q <= tx_last_q[15];
                    tx_sh_q <= {tx_last_q[14:0], 1'b0};
                end
            end else if (tx_st_q == TX_SHIFT) begin
                tx_out_q <= tx_sh_q[15];
                tx_sh_q <= {tx_sh_q[14:0], 1'b0};
                tx_cnt_q <= tx_cnt_q + 4'h1;
                if (tx_cnt_q == 4'hF) begin
                    tx_slot_q <= (tx_slot_q == last_slot || ondem)
                               ? 5'h00 : tx_slot_q + 5'h01;
                    if (ondem)
                        tx_st_q <= TX_IDLE;
                end
            end else begin
                tx_drive_q <= 1'b0;
            end
        end
    end

    // Transmit buffer, empty and underrun flags
    always_ff @(posedge ref_clk) begin
        if (eng_rst) begin
            tx_buf_q <= 16'h0000;
            tde_q <= 1'b1;
            tue_q <= 1'b0;
            tue_arm_q <= 1'b0;
            null_q <= 1'b0;
            tls_q <= 1'b0;
        end else if (clk_en) begin
            if (rd_stat && tue_q)
                tue_arm_q <= 1'b1;
            if (rd_stat)
                tls_q <= 1'b0;
            // Only one word may wait in on-demand mode
            if (wr_tx && (tde_q || !ondem)) begin
                tx_buf_q <= wr_data;
                tde_q <= 1'b0;
                null_q <= 1'b0;
            end else if (wr_null) begin
                tde_q <= 1'b0;
                null_q <= 1'b1;
            end else if (tx_start && clk_en) begin
                tde_q <= 1'b1;
            end
            if ((wr_tx || wr_null) && tue_arm_q) begin
                tue_q <= 1'b0;
                tue_arm_q <= 1'b0;
            end
            if (underrun)
                tue_q <= 1'b1;
            if (tx_start && net && !ondem && tx_slot_q == last_slot)
                tls_q <= 1'b1;
        end
    end

    // Register read mux, data one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data_q <= 16'h0000;
        end else if (clk_en && rd_en) begin
            case (addr)
                A_PFUNC: rd_data_q <= {8'h00, pen_q, 1'b0, psel_q};
                A_PDIR: rd_data_q <= {10'h000, pdir_q};
                A_PDATA: rd_data_q <= {10'h000,
                    (pdir_q & pdat_q) | (~pdir_q & sync2_q)};
                A_CTL1: rd_data_q <= {8'h00, ctl1_q};
                A_CTL2: rd_data_q <= {8'h00, ctl2_q};
                A_CTL3: rd_data_q <= {8'h00, ctl3_q};
                A_STAT: rd_data_q <= {8'h00, rdf_q, tde_q, roe_q, tue_q,
                    2'b00, tls_q, rls_q};
                A_RXD: rd_data_q <= rx_buf_q;
                default: rd_data_q <= 16'h0000;
            endcase
        end
    end
    assign rd_data = rd_data_q;

    // Exception conditions, each gated by its enable
    logic e_rxe, e_rx, e_rls, e_txe, e_tls, e_tx;
    assign e_rxe = ctl2_q[`C2_REIE] & rdf_q & roe_q;
    assign e_rx = ctl2_q[`C2_RIE] & rdf_q & ~roe_q;
    assign e_rls = ctl2_q[`C2_RLIE] & rls_q & net;
    assign e_txe = ctl2_q[`C2_TEIE] & tde_q & tue_q;
    assign e_tls = ctl2_q[`C2_TLIE] & tls_q & net;
    assign e_tx = ctl2_q[`C2_TIE] & tde_q & ~tue_q;

    // Fixed priority encode of pending exceptions
    always_comb begin
        if (e_rxe)
            exc_code = EXC_RX_ERR;
        else if (e_rx)
            exc_code = EXC_RX;
        else if (e_rls)
            exc_code = EXC_RX_LAST;
        else if (e_txe)
            exc_code = EXC_TX_ERR;
        else if (e_tls)
            exc_code = EXC_TX_LAST;
        else if (e_tx)
            exc_code = EXC_TX;
        else
            exc_code = EXC_NONE;
    end
    assign exc_req = (exc_code != EXC_NONE);

    // Serial-side drive: tx sync and tx data are the only serial outputs
    logic [5:0] ser_o, ser_oe;
    always_comb begin
        ser_o = 6'h00;
        ser_oe = 6'h00;
        ser_o[`PIN_TFS] = tx_fs_q;
        ser_oe[`PIN_TFS] = ctl2_q[`C2_TX_EN] & ~ir;
        ser_o[`PIN_TXD] = tx_out_q;
        // Null slots and gaps leave the data pin floating
        ser_oe[`PIN_TXD] = tx_drive_q;
    end

    // Pin mux: serial or GPIO per pin, all off without port enable
    assign pin_o = (psel_q & ser_o) | (~psel_q & pdat_q);
    assign pin_oe = {6{pen_q}}
                  & ((psel_q & ser_oe) | (~psel_q & pdir_q));
endmodule

// File: shared/sync_serial_cfg.svh
// Offsets, field positions and reset values for the serial port block
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH
`define ADR_A_PDATA 16'hFFBD
`define ADR_A_PDIR 16'hFFBE
`define ADR_A_PFUNC 16'hFFBF
`define ADR_A_CTL1 16'hFFB0
`define ADR_A_CTL2 16'hFFB1
`define ADR_A_CTL3 16'hFFB2
`define ADR_A_STAT 16'hFFB3
`define ADR_A_RXD 16'hFFB4
`define ADR_A_TXD 16'hFFB5
`define ADR_A_NULL 16'hFFB6
`define ADR_B_PDATA 16'hFFAD
`define ADR_B_PDIR 16'hFFAE
`define ADR_B_PFUNC 16'hFFAF
`define ADR_B_CTL1 16'hFFA0
`define ADR_B_CTL2 16'hFFA1
`define ADR_B_CTL3 16'hFFA2
`define ADR_B_STAT 16'hFFA3
`define ADR_B_RXD 16'hFFA4
`define ADR_B_TXD 16'hFFA5
`define ADR_B_NULL 16'hFFA6
`define PIN_RST 6'h00
`define PFUNC_EN_BIT 7
`define CTL_RST 8'h00
`define C2_TX_EN 0
`define C2_RX_EN 1
`define C2_TIE 2
`define C2_RIE 3
`define C2_TEIE 4
`define C2_REIE 5
`define C2_TLIE 6
`define C2_RLIE 7
`define C3_SLOTS 0
`define C3_SHARED 1
`define ST_RLS 0
`define ST_TLS 1
`define ST_UNDER 4
`define ST_OVER 5
`define ST_TEMPTY 6
`define ST_RFULL 7
`define WORD_BITS 16
`define PIN_SCLK 0
`define PIN_RFS 1
`define PIN_TFS 2
`define PIN_TXD 3
`define PIN_RXD 4
`endif

// File: shared/sync_serial_pkg.sv
// Types shared by the serial port block
package sync_serial_pkg;
    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum logic [2:0] {
        EXC_NONE, EXC_RX_ERR, EXC_RX, EXC_RX_LAST,
        EXC_TX_ERR, EXC_TX_LAST, EXC_TX
    } exc_code_t;
endpackage

// File: bench/sync_serial_sva.sv
// Checker for pin, register and exception behaviour of the serial port
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
module sync_serial_sva
    import sync_serial_pkg::*;
#(
    parameter bit PORT_B = 1'b0 // Selects the second register bank
) (
    input logic ref_clk, // System clock
    input logic sys_rst, // Synchronous reset
    input logic clk_en, // Clock enable
    input logic [15:0] addr, // Register address
    input logic [15:0] wr_data, // Write data
    input logic wr_en, // Write strobe
    input logic rd_en, // Read strobe
    input logic [15:0] rd_data, // Read data
    input logic [5:0] pin_i, // Pad levels
    input logic [5:0] pin_o, // Pad drive values
    input logic [5:0] pin_oe, // Pad drive enables
    input logic exc_req, // Exception pending
    input exc_code_t exc_code // Highest exception
);
    localparam logic [15:0] A_FN = PORT_B ? `ADR_B_PFUNC : `ADR_A_PFUNC;
    localparam logic [15:0] A_DIR = PORT_B ? `ADR_B_PDIR : `ADR_A_PDIR;
    localparam logic [15:0] A_DAT = PORT_B ? `ADR_B_PDATA : `ADR_A_PDATA;
    localparam logic [15:0] A_C1 = PORT_B ? `ADR_B_CTL1 : `ADR_A_CTL1;
    localparam logic [15:0] A_C3 = PORT_B ? `ADR_B_CTL3 : `ADR_A_CTL3;
    localparam logic [15:0] A_RX = PORT_B ? `ADR_B_RXD : `ADR_A_RXD;
    localparam logic [15:0] A_TX = PORT_B ? `ADR_B_TXD : `ADR_A_TXD;
    localparam logic [15:0] A_NUL = PORT_B ? `ADR_B_NULL : `ADR_A_NULL;
    logic [7:0] fn_q;
    logic [5:0] dir_q;
    logic [5:0] dat_q;
    logic [5:0] ctl_q;
    logic wok;
    logic rok;
    logic [5:0] gp;
    logic demand;
    assign wok = wr_en && clk_en;
    assign rok = rd_en && clk_en;
    assign gp = ~fn_q[5:0];
    assign demand = ctl_q[5] && ctl_q[4:0] == 5'h00;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Shadow copies, reserved bits dropped so stray writes cannot leak in
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fn_q <= 8'h00;
            dir_q <= 6'h00;
            dat_q <= 6'h00;
            ctl_q <= 6'h00;
        end else if (wok) begin
            if (addr == A_FN) fn_q <= {wr_data[7], 1'b0, wr_data[5:0]};
            if (addr == A_DIR) dir_q <= wr_data[5:0];
            if (addr == A_DAT) dat_q <= wr_data[5:0];
            if (addr == A_C1) ctl_q[4:0] <= wr_data[4:0];
            if (addr == A_C3) ctl_q[5] <= wr_data[`C3_SLOTS];
        end
    end
    property p_pen_off; !fn_q[7] |-> pin_oe == 6'h00; endproperty
    a_pen_off: assert property (p_pen_off) else $error("pin driven, port off");
    property p_rsv; $past(rok && addr == A_FN) |-> rd_data[15:8] == 8'h00 && !rd_data[6]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read set");
    property p_dir; fn_q[7] |-> (pin_oe & gp) == (dir_q & gp); endproperty
    a_dir: assert property (p_dir) else $error("gpio direction wrong");
    property p_out; fn_q[7] |-> (pin_o & pin_oe & gp) == (dat_q & dir_q & gp); endproperty
    a_out: assert property (p_out) else $error("gpio output level wrong");
    property p_dir_rd; $past(rok && addr == A_DIR) |-> rd_data == {10'h000, $past(dir_q)}; endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("direction readback wrong");
    property p_ser_in; (pin_oe & fn_q[5:0] & 6'h33) == 6'h00; endproperty
    a_ser_in: assert property (p_ser_in) else $error("serial input driven");
    property p_req; exc_req == (exc_code != EXC_NONE); endproperty
    a_req: assert property (p_req) else $error("request and code disagree");
    sequence s_iso; fn_q[5:0] == 6'h00 ##1 fn_q[5:0] == 6'h00; endsequence
    property p_iso; s_iso |-> exc_code inside {EXC_NONE, EXC_TX}; endproperty
    a_iso: assert property (p_iso) else $error("status alive in port reset");
    property p_rx_clr; $past(rok && addr == A_RX) |-> exc_code != EXC_RX; endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("rx request not cleared");
    property p_tx_clr;
        $past(wok && (addr == A_TX || addr == A_NUL) && fn_q[5:0] != 6'h00) |-> exc_code != EXC_TX;
    endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("tx request not cleared");
    property p_no_under; demand |-> exc_code != EXC_TX_ERR; endproperty
    a_no_under: assert property (p_no_under) else $error("underrun on demand");
    c_rx_err: cover property (exc_code == EXC_RX_ERR);
    c_rx_last: cover property (exc_code == EXC_RX_LAST);
    c_tx_err: cover property (exc_code == EXC_TX_ERR);
    c_demand: cover property (demand && fn_q[2] && pin_oe[2]);
endmodule

bind sync_serial_port sync_serial_sva #(.PORT_B(PORT_B)) chk (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .exc_req(exc_req), .exc_code(exc_code));

// File: bench/serial_codec_model.sv
// Far-side codec: bit clock, receive framing and a transmit word catcher
`timescale 1ns/1ps
module serial_codec_model (
    output logic sclk, // Bit clock, still outside frames
    output logic rfs, // Receive frame sync into the port
    output logic rxd, // Receive data into the port
    input logic tfs, // Transmit frame sync from the port
    input logic txd, // Transmit data from the port
    output logic [15:0] tx_seen, // Last whole word caught
    output logic [7:0] tx_words // Words caught so far
);
    logic [15:0] sh = 16'h0000;
    int cnt = -1;
    initial begin
        sclk = 1'b0;
        rfs = 1'b0;
        rxd = 1'b0;
        tx_seen = 16'h0000;
        tx_words = 8'h00;
    end
    // One 16-bit slot; tx sampled late in the bit, clear of the sync delay
    task automatic frame(input logic [15:0] w, input logic snd);
        for (int i = 0; i < 16; i++) begin
            sclk = 1'b1;
            rfs = snd && i == 0;
            rxd = snd ? w[15 - i] : ~rxd;
            #32 sclk = 1'b0;
            #31;
            if (tfs === 1'b1 && cnt < 0) cnt = 0;
            if (cnt >= 0) begin
                sh = {sh[14:0], txd};
                cnt++;
            end
            if (cnt == 16) begin
                tx_seen = sh;
                tx_words++;
                cnt = -1;
            end
            #1;
        end
        rfs = 1'b0;
        rxd = ~rxd; // Released line must not look like held data
        #64;
    endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
module testbench
    import sync_serial_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wr_data = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [15:0] rd_data;
    logic [5:0] pin_i;
    logic [5:0] pin_o;
    logic [5:0] pin_oe;
    logic [5:0] gpio_ext = 6'h00;
    logic [5:0] ins [2] = '{6'h24, 6'h08};
    logic exc_req;
    exc_code_t exc_code;
    logic p_sclk;
    logic p_rfs;
    logic p_rxd;
    logic [15:0] tx_seen;
    logic [7:0] tx_words;
    logic [7:0] w0;
    int fails = 0;
    int total_checks = 0;
    always #4 ref_clk = ~ref_clk;
    // Pad level: the port wins where it drives, else the far side
    assign pin_i = (pin_oe & pin_o) |
        (~pin_oe & {gpio_ext[5], p_rxd, gpio_ext[3:2], p_rfs, p_sclk});
    sync_serial_port #(.PORT_B(1'b0)) uut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .clk_en(clk_en), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .exc_req(exc_req), .exc_code(exc_code));
    serial_codec_model part (.sclk(p_sclk), .rfs(p_rfs), .rxd(p_rxd),
        .tfs(pin_i[2]), .txd(pin_i[3]), .tx_seen(tx_seen), .tx_words(tx_words));
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    // Read data stand from the cycle after the strobe until the next read
    task automatic rdc(input logic [15:0] a, input logic [15:0] m,
        input logic [15:0] e, input string n);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 chk(n, rd_data & m, e);
    endtask
    task automatic exc(input exc_code_t e);
        #1 chk("exc_code", {13'h0000, exc_code}, {13'h0000, e});
        chk("exc_req", {15'h0000, exc_req}, {15'h0000, e != EXC_NONE});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Whole run is about ten link frames; far more than that means a hang
    initial begin
        #200000;
        fails++;
        wrap_up;
    end
    initial begin
        idle(6);
        sys_rst <= 1'b0;
        rdc(`ADR_A_PDIR, 16'hFFFF, 16'h0000, "pdir reset");
        rdc(`ADR_A_PDATA, 16'hFFFF, 16'h0000, "pdata reset");
        rdc(`ADR_A_PFUNC, 16'hFFFF, 16'h0000, "pfunc reset");
        rdc(16'hFF00, 16'hFFFF, 16'h0000, "unmapped");
        wr(`ADR_A_PFUNC, 16'hFFC0);
        rdc(`ADR_A_PFUNC, 16'hFFFF, 16'h0080, "pfunc rsv");
        wr(`ADR_A_PDIR, 16'hFFD3);
        rdc(`ADR_A_PDIR, 16'hFFFF, 16'h0013, "pdir rsv");
        wr(`ADR_A_PDATA, 16'hFFFF);
        #1 chk("gpio oe", {10'h000, pin_oe}, 16'h0013);
        chk("gpio out", {10'h000, pin_o & pin_oe}, 16'h0013);
        foreach (ins[i]) begin
            gpio_ext <= ins[i];
            idle(4);
            rdc(`ADR_A_PDATA, 16'h002C, {10'h000, ins[i]}, "gpio in");
        end
        wr(`ADR_A_PFUNC, 16'h0000);
        #1 chk("pen off", {10'h000, pin_oe}, 16'h0000);
        $display("test gpio done");
        gpio_ext <= 6'h00;
        wr(`ADR_A_PFUNC, 16'h00BF);
        #1 chk("serial in", {10'h000, pin_oe & 6'h33}, 16'h0000);
        wr(`ADR_A_CTL2, 16'h003F);
        exc(EXC_TX);
        wr(`ADR_A_NULL, 16'h0000);
        exc(EXC_NONE);
        wr(`ADR_A_TXD, 16'hA5C3);
        exc(EXC_NONE);
        w0 = tx_words;
        part.frame(16'h1234, 1'b1);
        idle(8);
        chk("tx word", tx_seen, 16'hA5C3);
        chk("tx count", {8'h00, tx_words - w0}, 16'h0001);
        exc(EXC_RX);
        rdc(`ADR_A_RXD, 16'hFFFF, 16'h1234, "rx word");
        exc(EXC_TX);
        part.frame(16'h5678, 1'b1);
        idle(8);
        chk("resend", tx_seen, 16'hA5C3);
        exc(EXC_RX);
        part.frame(16'h9ABC, 1'b1);
        idle(8);
        exc(EXC_RX_ERR);
        rdc(`ADR_A_STAT, 16'h00F3, 16'h00F0, "status err");
        rdc(`ADR_A_RXD, 16'hFFFF, 16'h5678, "rx kept");
        exc(EXC_TX_ERR);
        rdc(`ADR_A_STAT, 16'h0010, 16'h0010, "status under");
        wr(`ADR_A_TXD, 16'h0F0F);
        exc(EXC_NONE);
        wr(`ADR_A_PFUNC, 16'h0080);
        idle(2);
        rdc(`ADR_A_STAT, 16'h00F3, 16'h0040, "status iso");
        rdc(`ADR_A_CTL2, 16'h00FF, 16'h003F, "ctl kept");
        $display("test normal done");
        wr(`ADR_A_CTL1, 16'h0001);
        wr(`ADR_A_CTL3, 16'h0003);
        wr(`ADR_A_CTL2, 16'h00C3);
        wr(`ADR_A_PFUNC, 16'h00BF);
        wr(`ADR_A_TXD, 16'h00FF);
        part.frame(16'h4321, 1'b1);
        part.frame(16'h0000, 1'b0);
        idle(8);
        chk("slot word", tx_seen, 16'h00FF);
        exc(EXC_RX_LAST);
        rdc(`ADR_A_STAT, 16'h0003, 16'h0003, "last slots");
        exc(EXC_NONE);
        wr(`ADR_A_PFUNC, 16'h0080);
        wr(`ADR_A_CTL1, 16'h0000);
        wr(`ADR_A_CTL2, 16'h0011);
        wr(`ADR_A_PFUNC, 16'h00BF);
        #1 chk("fs out", {15'h0000, pin_oe[2]}, 16'h0001);
        w0 = tx_words;
        part.frame(16'h0000, 1'b0);
        idle(8);
        rdc(`ADR_A_STAT, 16'h0010, 16'h0000, "no under");
        chk("no frame", {8'h00, tx_words - w0}, 16'h0000);
        wr(`ADR_A_TXD, 16'h3C3C);
        wr(`ADR_A_TXD, 16'hFFFF);
        part.frame(16'h0000, 1'b0);
        part.frame(16'h0000, 1'b0);
        idle(8);
        chk("demand word", tx_seen, 16'h3C3C);
        chk("demand count", {8'h00, tx_words - w0}, 16'h0001);
        $display("test modes done");
        wrap_up;
    end
endmodule
